/* dv/ltid_mem_model.sv */
// Program memory responder for table accesses
`timescale 1ns/1ps
module ltid_mem_model
    import ltid_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    // Table access
    input  wire ltid_tbl_req_t tbl_req,
    output logic               tbl_done,
    output logic [7:0]         tbl_rdata
);
    logic [1:0] wait_ff;
    logic       hold_ff;

    // Random latency, one done pulse per request, data scrambled outside the done cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tbl_done  <= 1'b0;
            wait_ff   <= 2'h0;
            hold_ff   <= 1'b0;
            tbl_rdata <= 8'h00;
        end else if (tbl_done) begin
            tbl_done  <= 1'b0;
            hold_ff   <= 1'b1;
            tbl_rdata <= ~tbl_rdata;
        end else if (hold_ff || !tbl_req.req) begin
            hold_ff   <= 1'b0;
            wait_ff   <= 2'($urandom_range(0, 2));
            tbl_rdata <= ~tbl_rdata;
        end else if (wait_ff != 2'h0) begin
            wait_ff   <= wait_ff - 2'h1;
            tbl_rdata <= ~tbl_rdata;
        end else begin
            tbl_done  <= 1'b1;
            tbl_rdata <= tbl_req.addr[7:0] ^ 8'h5a;
        end
    end
endmodule

/* dv/test_ltid_decode.sv */
// Self-checking testbench for the literal and table instruction decoder
`timescale 1ns/1ps
module test_ltid_decode
    import ltid_pkg::*;
;
    typedef struct {int sel; logic [31:0] e;} ltid_note_t;
    logic          mclk = 1'b0;
    logic          sys_rst = 1'b1;
    logic          ext_set_en = 1'b0;
    ltid_fetch_t   fetch = '0;
    logic [5:0]    reg_bank_in = 6'h00;
    logic          tbl_done;
    logic [7:0]    tbl_rdata;
    logic          busy;
    logic [5:0]    reg_bank_eff;
    ltid_tbl_req_t tbl_req;
    logic [7:0]    wr_o, tl_o;
    logic [4:0]    st_o;
    logic [5:0]    bk_o;
    logic [15:0]   pr_o, pw_o;
    logic [13:0]   p_o [3];
    logic [21:0]   tp_o;
    logic          rp_o, pv_o;
    int            miscompares = 0;
    int            n_tests = 0;
    ltid_note_t    q[$];
    logic [7:0]    e_w = 8'h00, e_l = 8'h00;
    logic [4:0]    e_s = 5'h00;
    logic [15:0]   e_prod = 16'h0000;
    logic [13:0]   e_p [3] = '{14'h0000, 14'h0000, 14'h0000};
    logic [21:0]   e_tp = 22'h000000;
    logic [7:0]    ops [7] = '{OP_LOAD_IMM, OP_ADD_IMM, OP_RSUB_IMM, OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM, OP_MUL_IMM};

    always #50 mclk = ~mclk;

    ltid_decode #(.PTR_W(14)) ltid_decode_i (.mclk(mclk), .sys_rst(sys_rst), .fetch(fetch), .ext_set_en(ext_set_en),
        .busy(busy), .reg_bank_in(reg_bank_in), .reg_bank_eff(reg_bank_eff), .tbl_req(tbl_req), .tbl_done(tbl_done),
        .tbl_rdata(tbl_rdata), .working_register_ff(wr_o), .status_ff(st_o), .bank_select_register_ff(bk_o),
        .product_ff(pr_o), .ptr0_ff(p_o[0]), .ptr1_ff(p_o[1]), .ptr2_ff(p_o[2]), .tbl_ptr_ff(tp_o),
        .tbl_latch_ff(tl_o), .ret_pulse_ff(rp_o), .pass_word_ff(pw_o), .pass_valid_ff(pv_o));

    ltid_mem_model ltid_mem_model_i (.mclk(mclk), .sys_rst(sys_rst), .tbl_req(tbl_req), .tbl_done(tbl_done),
        .tbl_rdata(tbl_rdata));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] obs(input int sel);
        case (sel)
            0: obs = {24'h0, wr_o};
            1: obs = {27'h0, st_o};
            2: obs = {26'h0, bk_o};
            3: obs = {16'h0, pr_o};
            4, 5, 6: obs = {18'h0, p_o[sel-4]};
            7: obs = {10'h0, tp_o};
            8: obs = {24'h0, tl_o};
            9: obs = {31'h0, rp_o};
            10: obs = {31'h0, busy};
            11: obs = {26'h0, reg_bank_eff};
            12: obs = {8'h0, tbl_req.req, tbl_req.write, tbl_req.addr};
            13: obs = {24'h0, tbl_req.wdata};
            14: obs = {16'h0, pw_o};
            default: obs = {31'h0, pv_o};
        endcase
    endfunction

    task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk(input int sel, input logic [31:0] e);
        q.push_back('{sel, e});
    endtask

    task automatic conclude();
        repeat (2) @(negedge mclk);
        $display("Counts: %0d compares, %0d mismatches", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic issue(input logic [15:0] w);
        @(negedge mclk);
        fetch = '{1'b1, w};
        @(negedge mclk);
        fetch.valid = 1'b0;
    endtask

    task automatic settle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            @(negedge mclk);
            n++;
        end
    endtask

    task automatic alu(input logic [7:0] op, input logic [7:0] k);
        logic [8:0] r;
        logic [4:0] h;
        logic       wrap;
        r = {1'b0, e_w} + {1'b0, k};
        h = {1'b0, e_w[3:0]} + {1'b0, k[3:0]};
        wrap = (e_w[7] == k[7]) && (r[7] != k[7]);
        if (op == OP_RSUB_IMM) begin
            r = {1'b0, k} + {1'b0, ~e_w} + 9'h001;
            h = {1'b0, k[3:0]} + {1'b0, ~e_w[3:0]} + 5'h01;
            wrap = (k[7] != e_w[7]) && (r[7] != k[7]);
        end
        case (op)
            OP_ADD_IMM, OP_RSUB_IMM: begin
                e_s = {r[7], wrap, r[7:0] == 8'h00, h[4], r[8]};
                e_w = r[7:0];
            end
            OP_AND_IMM: e_w = e_w & k;
            OP_OR_IMM: e_w = e_w | k;
            OP_XOR_IMM: e_w = e_w ^ k;
            OP_MUL_IMM: e_prod = {8'h00, e_w} * {8'h00, k};
            default: e_w = k;
        endcase
        if (op == OP_AND_IMM || op == OP_OR_IMM || op == OP_XOR_IMM) begin
            e_s[FLAG_Z] = e_w == 8'h00;
            e_s[FLAG_N] = e_w[7];
        end
    endtask

    task automatic push_alu();
        chk(0, e_w);
        chk(1, e_s);
        chk(3, e_prod);
    endtask

    task automatic push_ptr();
        for (int j = 0; j < 3; j++)
            chk(4 + j, e_p[j]);
        chk(1, e_s);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scoreboard side: compares the oldest notes once the outputs have settled
    initial forever begin
        @(negedge mclk);
        #2;
        while (q.size() > 0) begin
            ltid_note_t nt;
            nt = q.pop_front();
            compare(obs(nt.sel), nt.e);
        end
    end

    initial begin
        #(100 * 20000);
        miscompares++;
        conclude();
    end

    initial begin
        logic [7:0]  k;
        logic [13:0] v;
        logic [21:0] a;
        int          j;
        void'($urandom(50367));
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        // Literal group, back to back
        for (int i = 0; i < 28; i++) begin
            k = (i == 9) ? 8'h00 : 8'($urandom);
            @(negedge mclk);
            if (i > 0)
                push_alu();
            fetch = '{1'b1, {ops[i % 7], k}};
            alu(ops[i % 7], k);
        end
        @(negedge mclk);
        push_alu();
        fetch.valid = 1'b0;
        $display("Test literal group done");
        // Return takes a second cycle
        k = 8'($urandom);
        issue({OP_RET_IMM, k});
        e_w = k;
        chk(9, 1);
        chk(10, 1);
        push_alu();
        @(negedge mclk);
        chk(9, 0);
        chk(10, 0);
        reg_bank_in = 6'($urandom) | 6'h30;
        k = 8'($urandom) & 8'h3f;
        issue({OP_BANK_HI, BANK_MID, k[5:0]});
        chk(2, k);
        chk(11, {2'h0, reg_bank_in[3:0]});
        chk(1, e_s);
        $display("Test return and bank done");
        // Two-word pointer load for every selector
        for (int f = 0; f < 4; f++) begin
            v = 14'($urandom);
            @(negedge mclk);
            fetch = '{1'b1, {OP_LDPTR_HI, LDPTR_MID, 2'(f), v[13:10]}};
            @(negedge mclk);
            fetch.word = {LDPTR_W2_HI, v[9:0]};
            @(negedge mclk);
            fetch.valid = 1'b0;
            e_p[(f == 3) ? 2 : f] = v;
            push_ptr();
        end
        issue({LDPTR_W2_HI, 10'h155});
        push_ptr();
        chk(15, 0);
        issue({OP_PADD_HI, 2'h1, 6'h3f});
        push_ptr();
        chk(15, 1);
        ext_set_en = 1'b1;
        for (int f = 0; f < 8; f++) begin
            k = 8'($urandom) & 8'h3f;
            j = ((f % 4) == 3) ? 2 : (f % 4);
            issue({(f < 4) ? OP_PADD_HI : OP_PSUB_HI, 2'(f), k[5:0]});
            e_p[j] = (f < 4) ? e_p[j] + {8'h00, k[5:0]} : e_p[j] - {8'h00, k[5:0]};
            push_ptr();
        end
        issue(16'h6abc);
        chk(14, 16'h6abc);
        chk(15, 1);
        push_alu();
        $display("Test pointers and pass-through done");
        // Table reads then writes in all four pointer modes
        for (int t = 0; t < 8; t++) begin
            a = (t % 4 == 3) ? e_tp + 22'h1 : e_tp;
            issue(16'h0008 + 16'(t));
            chk(12, {1'b1, t >= 4, a});
            if (t >= 4)
                chk(13, e_l);
            settle();
            if (t < 4)
                e_l = a[7:0] ^ 8'h5a;
            e_tp = (t % 4 == 2) ? e_tp - 22'h1 : (t % 4 == 0) ? e_tp : e_tp + 22'h1;
            chk(7, e_tp);
            chk(8, e_l);
            chk(1, e_s);
            chk(10, 0);
        end
        $display("Test table access done");
        conclude();
    end
endmodule

/* inc/ltid_pkg.sv */
// Constants and types for the literal and table instruction decoder
package ltid_pkg;
    localparam logic [7:0] OP_ADD_IMM   = 8'h0f;
    localparam logic [7:0] OP_AND_IMM   = 8'h0b;
    localparam logic [7:0] OP_OR_IMM    = 8'h09;
    localparam logic [7:0] OP_XOR_IMM   = 8'h0a;
    localparam logic [7:0] OP_RSUB_IMM  = 8'h08;
    localparam logic [7:0] OP_LOAD_IMM  = 8'h0e;
    localparam logic [7:0] OP_MUL_IMM   = 8'h0d;
    localparam logic [7:0] OP_RET_IMM   = 8'h0c;
    localparam logic [7:0] OP_BANK_HI   = 8'h01;
    localparam logic [1:0] BANK_MID     = 2'h0;
    localparam logic [7:0] OP_LDPTR_HI  = 8'hee;
    localparam logic [1:0] LDPTR_MID    = 2'h0;
    localparam logic [5:0] LDPTR_W2_HI  = 6'h3c;
    localparam logic [7:0] OP_PADD_HI   = 8'he8;
    localparam logic [7:0] OP_PSUB_HI   = 8'he9;
    localparam logic [12:0] OP_TBL_HI   = 13'h0001;
    localparam logic [15:0] OP_NOP      = 16'h0000;
    localparam int          FLAG_C      = 0;
    localparam int          FLAG_DC     = 1;
    localparam int          FLAG_Z      = 2;
    localparam int          FLAG_SWRAP  = 3;
    localparam int          FLAG_N      = 4;
    localparam logic [4:0]  STATUS_RST  = 5'h00;
    localparam logic [7:0]  WORK_REG_RST = 8'h00;
    localparam logic [5:0]  BANK_RST    = 6'h00;
    localparam logic [13:0] PTR_RST     = 14'h0000;
    localparam logic [1:0]  BANK_HI_FORCE = 2'h0;
    // Table modes in low two opcode bits
    localparam logic [1:0]  TBL_NONE    = 2'h0;
    localparam logic [1:0]  TBL_POSTINC = 2'h1;
    localparam logic [1:0]  TBL_POSTDEC = 2'h2;
    localparam logic [1:0]  TBL_PREINC  = 2'h3;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } ltid_fetch_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [21:0] addr;
        logic [7:0]  wdata;
    } ltid_tbl_req_t;
endpackage

/* verilog/ltid_decode.sv */
// Literal and table-access instruction decode and execute
//
// Behaviour
// - add_immediate adds literal to working register, updates all five flags
// - and_immediate ANDs literal into working register, updates Z N only
// - or_immediate ORs literal into working register, updates Z N only
// - xor_immediate XORs literal into working register, updates Z N only
// - reverse_subtract_immediate computes literal minus working register, updates all five flags
// - load_immediate copies literal into working register, flags untouched
// - multiply_immediate multiplies working register by literal, flags untouched
// - return_with_immediate loads literal and returns, two cycles, flags untouched
// - set_bank_immediate writes six-bit literal into bank select register
// - pointer_add_immediate adds six-bit literal to selected pointer
// - pointer_subtract_immediate subtracts six-bit literal from selected pointer
// - Table read modes: none, post-inc, post-dec, pre-inc; no flags
// - Table write modes: none, post-inc, post-dec, pre-inc; no flags
// - Program counter change adds one extra NOP cycle
// - Lone second words decode as NOP
// - Register-field bank bits two MSBs forced to zero
// - Extended set enable low disables extended instructions
`timescale 1ns/1ps
module ltid_decode
    import ltid_pkg::*;
#(
    parameter int PTR_W = 14
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    // Fetch side
    input  wire ltid_fetch_t   fetch,
    input  wire logic          ext_set_en,
    output logic               busy,
    // Register-field bank for other decode
    input  wire logic [5:0]    reg_bank_in,
    output logic [5:0]         reg_bank_eff,
    // Table access
    output ltid_tbl_req_t      tbl_req,
    input  wire logic          tbl_done,
    input  wire logic [7:0]    tbl_rdata,
    // Architectural state
    output logic [7:0]         working_register_ff,
    output logic [4:0]         status_ff,
    output logic [5:0]         bank_select_register_ff,
    output logic [15:0]        product_ff,
    output logic [PTR_W-1:0]   ptr0_ff,
    output logic [PTR_W-1:0]   ptr1_ff,
    output logic [PTR_W-1:0]   ptr2_ff,
    output logic [21:0]        tbl_ptr_ff,
    output logic [7:0]         tbl_latch_ff,
    output logic               ret_pulse_ff,
    output logic [15:0]        pass_word_ff,
    output logic               pass_valid_ff
);

    typedef enum logic [1:0] {
        LTID_IDLE  = 2'b00,
        LTID_WORD2 = 2'b01,
        LTID_TBL   = 2'b10,
        LTID_NOP   = 2'b11
    } ltid_state_t;

    ltid_state_t state_ff;
    ltid_state_t nxt_state;
    logic [1:0]  ldptr_sel_ff;
    logic [3:0]  ldptr_hi_ff;
    logic [1:0]  tbl_mode_ff;
    logic        tbl_wr_ff;

    function automatic logic [4:0] zn_flags(input logic [4:0] st, input logic [7:0] r);
        logic [4:0] o;
        o = st;
        o[FLAG_Z] = (r == 8'h00);
        o[FLAG_N] = r[7];
        return o;
    endfunction

    wire logic [7:0] lit  = fetch.word[7:0];
    wire logic [7:0] hi   = fetch.word[15:8];
    wire logic       take = fetch.valid && (state_ff == LTID_IDLE);
    wire logic       is_lit = (hi == OP_ADD_IMM) || (hi == OP_AND_IMM) || (hi == OP_OR_IMM)
                             || (hi == OP_XOR_IMM) || (hi == OP_RSUB_IMM) || (hi == OP_LOAD_IMM)
                             || (hi == OP_MUL_IMM) || (hi == OP_RET_IMM);
    wire logic       is_bank  = (hi == OP_BANK_HI) && (fetch.word[7:6] == BANK_MID);
    wire logic       is_ldptr = (hi == OP_LDPTR_HI) && (fetch.word[7:6] == LDPTR_MID);
    wire logic       is_padd  = ext_set_en && (hi == OP_PADD_HI);
    wire logic       is_psub  = ext_set_en && (hi == OP_PSUB_HI);
    wire logic       is_tbl   = (fetch.word[15:3] == OP_TBL_HI);
    wire logic       is_word2 = (fetch.word[15:10] == LDPTR_W2_HI);
    wire logic       is_mine  = is_lit || is_bank || is_ldptr || is_padd || is_psub || is_tbl || is_word2;
    // Adder for add_immediate and subtractor for reverse_subtract_immediate
    wire logic [8:0] add_sum  = {1'b0, working_register_ff} + {1'b0, lit};
    wire logic [4:0] add_half = {1'b0, working_register_ff[3:0]} + {1'b0, lit[3:0]};
    wire logic [8:0] sub_diff = {1'b0, lit} - {1'b0, working_register_ff};
    wire logic [4:0] sub_half = {1'b0, lit[3:0]} - {1'b0, working_register_ff[3:0]};

    // Upper bank bits held at zero for source/destination field addressing
    assign reg_bank_eff = {BANK_HI_FORCE, reg_bank_in[3:0]};
    assign busy = (state_ff != LTID_IDLE);

    //////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            LTID_IDLE: begin
                if (take && is_ldptr) begin
                    nxt_state = LTID_WORD2;
                end else if (take && is_tbl) begin
                    nxt_state = LTID_TBL;
                end else if (take && (hi == OP_RET_IMM)) begin
                    nxt_state = LTID_NOP;
                end
            end
            LTID_WORD2: begin
                if (fetch.valid) begin
                    nxt_state = LTID_IDLE;
                end
            end
            LTID_TBL: begin
                if (tbl_done) begin
                    nxt_state = LTID_IDLE;
                end
            end
            LTID_NOP: nxt_state = LTID_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_ff <= LTID_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Working register, flags, product
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            working_register_ff <= WORK_REG_RST;
            status_ff           <= STATUS_RST;
            product_ff          <= 16'h0000;
            ret_pulse_ff        <= 1'b0;
        end else begin
            ret_pulse_ff <= 1'b0;
            if (take) begin
                unique case (hi)
                    OP_ADD_IMM: begin
                        working_register_ff <= add_sum[7:0];
                        status_ff <= {add_sum[7], (working_register_ff[7] == lit[7]) && (add_sum[7] != lit[7]),
                                      (add_sum[7:0] == 8'h00), add_half[4], add_sum[8]};
                    end
                    OP_RSUB_IMM: begin
                        working_register_ff <= sub_diff[7:0];
                        status_ff <= {sub_diff[7], (lit[7] != working_register_ff[7]) && (sub_diff[7] != lit[7]),
                                      (sub_diff[7:0] == 8'h00), ~sub_half[4], ~sub_diff[8]};
                    end
                    OP_AND_IMM: begin
                        working_register_ff <= working_register_ff & lit;
                        status_ff <= zn_flags(status_ff, working_register_ff & lit);
                    end
                    OP_OR_IMM: begin
                        working_register_ff <= working_register_ff | lit;
                        status_ff <= zn_flags(status_ff, working_register_ff | lit);
                    end
                    OP_XOR_IMM: begin
                        working_register_ff <= working_register_ff ^ lit;
                        status_ff <= zn_flags(status_ff, working_register_ff ^ lit);
                    end
                    OP_LOAD_IMM: working_register_ff <= lit;
                    OP_MUL_IMM:  product_ff <= {8'h00, working_register_ff} * {8'h00, lit};
                    OP_RET_IMM: begin
                        working_register_ff <= lit;
                        ret_pulse_ff        <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Bank select and pointers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bank_select_register_ff <= BANK_RST;
            ptr0_ff                 <= PTR_RST;
            ptr1_ff                 <= PTR_RST;
            ptr2_ff                 <= PTR_RST;
            ldptr_sel_ff            <= 2'h0;
            ldptr_hi_ff             <= 4'h0;
        end else begin
            if (take && is_bank) begin
                bank_select_register_ff <= fetch.word[5:0];
            end
            if (take && is_ldptr) begin
                ldptr_sel_ff <= fetch.word[5:4];
                ldptr_hi_ff  <= fetch.word[3:0];
            end
            if (take && (is_padd || is_psub)) begin
                unique case (fetch.word[7:6])
                    2'h0: ptr0_ff <= is_padd ? ptr0_ff + PTR_W'(fetch.word[5:0])
                                             : ptr0_ff - PTR_W'(fetch.word[5:0]);
                    2'h1: ptr1_ff <= is_padd ? ptr1_ff + PTR_W'(fetch.word[5:0])
                                             : ptr1_ff - PTR_W'(fetch.word[5:0]);
                    default: ptr2_ff <= is_padd ? ptr2_ff + PTR_W'(fetch.word[5:0])
                                                : ptr2_ff - PTR_W'(fetch.word[5:0]);
                endcase
            end
            // Second word consumed only by its first word
            if (state_ff == LTID_WORD2 && fetch.valid && fetch.word[15:10] == LDPTR_W2_HI) begin
                unique case (ldptr_sel_ff)
                    2'h0: ptr0_ff <= PTR_W'({ldptr_hi_ff, fetch.word[9:0]});
                    2'h1: ptr1_ff <= PTR_W'({ldptr_hi_ff, fetch.word[9:0]});
                    default: ptr2_ff <= PTR_W'({ldptr_hi_ff, fetch.word[9:0]});
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Table access pointer and request
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tbl_ptr_ff   <= 22'h000000;
            tbl_latch_ff <= 8'h00;
            tbl_mode_ff  <= TBL_NONE;
            tbl_wr_ff    <= 1'b0;
        end else begin
            if (take && is_tbl) begin
                tbl_mode_ff <= fetch.word[1:0];
                tbl_wr_ff   <= fetch.word[2];
                if (fetch.word[1:0] == TBL_PREINC) begin
                    tbl_ptr_ff <= tbl_ptr_ff + 22'h000001;
                end
            end
            if (state_ff == LTID_TBL && tbl_done) begin
                if (!tbl_wr_ff) begin
                    tbl_latch_ff <= tbl_rdata;
                end
                if (tbl_mode_ff == TBL_POSTINC) begin
                    tbl_ptr_ff <= tbl_ptr_ff + 22'h000001;
                end else if (tbl_mode_ff == TBL_POSTDEC) begin
                    tbl_ptr_ff <= tbl_ptr_ff - 22'h000001;
                end
            end
        end
    end

    always_comb begin
        tbl_req.req   = (state_ff == LTID_TBL);
        tbl_req.write = tbl_wr_ff;
        tbl_req.addr  = tbl_ptr_ff;
        tbl_req.wdata = tbl_latch_ff;
    end

    //////////////////////////////////////////////////////////////////////////////
    // Foreign opcodes forwarded to other decode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pass_word_ff  <= OP_NOP;
            pass_valid_ff <= 1'b0;
        end else begin
            pass_valid_ff <= take && !is_mine;
            pass_word_ff  <= (take && !is_mine) ? fetch.word : OP_NOP;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    sequence s_ret_take;
        take && hi == OP_RET_IMM;
    endsequence

    a_add_result: assert property (@(posedge mclk) disable iff (sys_rst)
        take && hi == OP_ADD_IMM |=> working_register_ff == $past(working_register_ff) + $past(lit))
        else $error("add result wrong");
    a_and_flags: assert property (@(posedge mclk) disable iff (sys_rst)
        take && hi == OP_AND_IMM |=> status_ff[1:0] == $past(status_ff[1:0]))
        else $error("and changed carry");
    a_load_noflag: assert property (@(posedge mclk) disable iff (sys_rst)
        take && hi == OP_LOAD_IMM |=> status_ff == $past(status_ff) && working_register_ff == $past(lit))
        else $error("load wrong");
    a_ret_two_cyc: assert property (@(posedge mclk) disable iff (sys_rst)
        s_ret_take |=> busy ##1 !busy)
        else $error("return not two cycles");
    a_bank_write: assert property (@(posedge mclk) disable iff (sys_rst)
        take && is_bank |=> bank_select_register_ff == $past(fetch.word[5:0]))
        else $error("bank not written");
    a_ldptr_wait: assert property (@(posedge mclk) disable iff (sys_rst)
        take && is_ldptr |=> state_ff == LTID_WORD2)
        else $error("pointer load lost");
    a_lone_word2: assert property (@(posedge mclk) disable iff (sys_rst)
        take && is_word2 |=> !pass_valid_ff && $stable(ptr0_ff) && $stable(ptr1_ff) && $stable(ptr2_ff))
        else $error("lone second word not a no-op");
    a_bank_force: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_bank_eff[5:4] == 2'h0 && reg_bank_eff[3:0] == reg_bank_in[3:0])
        else $error("bank high bits set");
    a_ext_off: assert property (@(posedge mclk) disable iff (sys_rst)
        take && !ext_set_en && hi == OP_PADD_HI |=> $stable(ptr0_ff) && $stable(ptr1_ff))
        else $error("extended op ran");
    a_pass_foreign: assert property (@(posedge mclk) disable iff (sys_rst)
        take && !is_mine |=> pass_valid_ff && $stable(working_register_ff))
        else $error("foreign op not passed");
endmodule
